/* File: dscg_top.sv */
// deep-sleep clock gate controller with run and sleep companions, apb slave
`timescale 1ns/1ns
`include "dscg_defs.svh"

module dscg_top #(
  parameter int ADDR_W = 12,
  parameter int GATE_W = 32
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // power mode of the device
  input  wire dscg_pkg::dscg_mode_e     power_mode,
  // peripheral access check
  input  wire dscg_pkg::dscg_unit_req_s unit_req,
  output dscg_pkg::dscg_unit_resp_s     unit_resp,
  // clock enables
  output logic [GATE_W-1:0]             unit_clk_en,
  output dscg_pkg::dscg_unit_en_s       unit_en,
  // interrupt
  output logic                          irq
);
  import dscg_pkg::*;

  // byte-lane merge of a write, restricted to the writable bits
  function automatic logic [31:0] dscg_merge(input logic [31:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb,
                                             input logic [31:0] wmask);
    logic [31:0] lane_mask;
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return ((old_val & ~lane_mask) | (wdata & lane_mask)) & wmask;
  endfunction : dscg_merge

  logic [31:0]       run_clock_config_reg;
  logic [31:0]       run_clock_gate_1_reg;
  logic [31:0]       sleep_clock_gate_1_reg;
  logic [31:0]       deep_sleep_clock_gate_1_reg;
  logic [31:0]       irq_status_reg;
  logic [31:0]       irq_status_next;
  logic [31:0]       irq_mask_reg;
  logic [31:0]       prdata_reg;
  logic              pslverr_reg;
  logic [GATE_W-1:0] active_gate_reg;
  logic [GATE_W-1:0] active_gate_next;
  logic              setup_phase;
  logic              access_wr;
  logic              addr_hit;
  logic [31:0]       rd_value;
  logic              auto_clock_gating;
  logic [31:0]       set_events;
  logic [31:0]       clr_events;

  assign setup_phase       = psel & ~penable;
  // zero wait states, so every access phase completes at its first edge
  assign access_wr         = psel & penable & pwrite;
  assign auto_clock_gating = run_clock_config_reg[`DSCG_BIT_AUTO_GATING];

  // read decode; unmapped offsets answer with an error
  always_comb begin
    rd_value = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (paddr)
      `DSCG_OFF_RUN_CFG:    rd_value = run_clock_config_reg;
      `DSCG_OFF_RUN_GATE:   rd_value = run_clock_gate_1_reg;
      `DSCG_OFF_SLEEP_GATE: rd_value = sleep_clock_gate_1_reg;
      `DSCG_OFF_DEEP_GATE:  rd_value = deep_sleep_clock_gate_1_reg;
      `DSCG_OFF_IRQ_STATUS: rd_value = irq_status_reg;
      `DSCG_OFF_IRQ_MASK:   rd_value = irq_mask_reg;
      default:              addr_hit = 1'b0;
    endcase
  end

  // read data and error are captured in the setup cycle and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr_reg <= ~addr_hit;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // run-mode configuration, only the auto gating bit is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_clock_config_reg <= `DSCG_RUN_CFG_RESET;
    end else if (access_wr && paddr == `DSCG_OFF_RUN_CFG) begin
      run_clock_config_reg <= dscg_merge(run_clock_config_reg, pwdata, pstrb,
                                         `DSCG_RUN_CFG_WMASK);
    end
  end

  // run-mode gate register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_clock_gate_1_reg <= `DSCG_GATE_RESET;
    end else if (access_wr && paddr == `DSCG_OFF_RUN_GATE) begin
      run_clock_gate_1_reg <= dscg_merge(run_clock_gate_1_reg, pwdata, pstrb,
                                         `DSCG_GATE_WMASK);
    end
  end

  // sleep-mode gate register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_clock_gate_1_reg <= `DSCG_GATE_RESET;
    end else if (access_wr && paddr == `DSCG_OFF_SLEEP_GATE) begin
      sleep_clock_gate_1_reg <= dscg_merge(sleep_clock_gate_1_reg, pwdata, pstrb,
                                           `DSCG_GATE_WMASK);
    end
  end

  // deep-sleep gate register; the write mask keeps reserved bits at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_sleep_clock_gate_1_reg <= `DSCG_GATE_RESET;
    end else if (access_wr && paddr == `DSCG_OFF_DEEP_GATE) begin
      deep_sleep_clock_gate_1_reg <= dscg_merge(deep_sleep_clock_gate_1_reg, pwdata,
                                                pstrb, `DSCG_GATE_WMASK);
    end
  end

  // source of the clock enables; without auto gating the run register rules
  always_comb begin
    active_gate_next = run_clock_gate_1_reg[GATE_W-1:0];
    if (auto_clock_gating) begin
      unique case (power_mode)
        dscg_mode_run:   active_gate_next = run_clock_gate_1_reg[GATE_W-1:0];
        dscg_mode_sleep: active_gate_next = sleep_clock_gate_1_reg[GATE_W-1:0];
        dscg_mode_deep:  active_gate_next = deep_sleep_clock_gate_1_reg[GATE_W-1:0];
        default:         active_gate_next = run_clock_gate_1_reg[GATE_W-1:0];
      endcase
    end
  end

  // registered so the gating cells see a glitch-free enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_gate_reg <= GATE_W'(`DSCG_GATE_RESET);
    end else begin
      active_gate_reg <= active_gate_next;
    end
  end

  assign unit_clk_en = active_gate_reg;

  // named enables, one per unit
  assign unit_en.comparator_b_gate   = active_gate_reg[`DSCG_BIT_COMPARATOR_B];
  assign unit_en.comparator_a_gate   = active_gate_reg[`DSCG_BIT_COMPARATOR_A];
  assign unit_en.gp_counter_d_gate   = active_gate_reg[`DSCG_BIT_GP_COUNTER_D];
  assign unit_en.gp_counter_c_gate   = active_gate_reg[`DSCG_BIT_GP_COUNTER_C];
  assign unit_en.gp_counter_b_gate   = active_gate_reg[`DSCG_BIT_GP_COUNTER_B];
  assign unit_en.gp_counter_a_gate   = active_gate_reg[`DSCG_BIT_GP_COUNTER_A];
  assign unit_en.two_wire_b_gate     = active_gate_reg[`DSCG_BIT_TWO_WIRE_B];
  assign unit_en.two_wire_a_gate     = active_gate_reg[`DSCG_BIT_TWO_WIRE_A];
  assign unit_en.sync_serial_b_gate  = active_gate_reg[`DSCG_BIT_SYNC_SERIAL_B];
  assign unit_en.sync_serial_a_gate  = active_gate_reg[`DSCG_BIT_SYNC_SERIAL_A];
  assign unit_en.async_serial_b_gate = active_gate_reg[`DSCG_BIT_ASYNC_SERIAL_B];
  assign unit_en.async_serial_a_gate = active_gate_reg[`DSCG_BIT_ASYNC_SERIAL_A];

  // fault answer for accesses toward gated units
  dscg_access_check #(
    .GATE_W (GATE_W)
  ) u_access_check (
    .pclk    (pclk),
    .presetn (presetn),
    .gate    (active_gate_reg),
    .req     (unit_req),
    .resp    (unit_resp)
  );

  // events: a faulted unit access, and a change of the active enables
  always_comb begin
    set_events = 32'h0000_0000;
    set_events[`DSCG_BIT_IRQ_FAULT]  = unit_resp.done & unit_resp.fault;
    set_events[`DSCG_BIT_IRQ_SWITCH] = active_gate_next != active_gate_reg;
    clr_events = 32'h0000_0000;
    if (access_wr && paddr == `DSCG_OFF_IRQ_STATUS) begin
      clr_events = dscg_merge(32'h0000_0000, pwdata, pstrb, `DSCG_IRQ_WMASK);
    end
    // a new event in the clearing cycle survives the clear
    irq_status_next = ((irq_status_reg & ~clr_events) | set_events) & `DSCG_IRQ_WMASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= `DSCG_IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= `DSCG_IRQ_RESET;
    end else if (access_wr && paddr == `DSCG_OFF_IRQ_MASK) begin
      irq_mask_reg <= dscg_merge(irq_mask_reg, pwdata, pstrb, `DSCG_IRQ_WMASK);
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

endmodule : dscg_top

/* File: dscg_defs.svh */
// offsets, field positions and reset values of the deep-sleep clock gate controller
`ifndef DSCG_DEFS_SVH
`define DSCG_DEFS_SVH

// register byte offsets
`define DSCG_OFF_RUN_CFG     12'h060
`define DSCG_OFF_RUN_GATE    12'h104
`define DSCG_OFF_SLEEP_GATE  12'h114
`define DSCG_OFF_DEEP_GATE   12'h124
`define DSCG_OFF_IRQ_STATUS  12'h200
`define DSCG_OFF_IRQ_MASK    12'h204

// gate register field positions
`define DSCG_BIT_COMPARATOR_B  25
`define DSCG_BIT_COMPARATOR_A  24
`define DSCG_BIT_GP_COUNTER_D  19
`define DSCG_BIT_GP_COUNTER_C  18
`define DSCG_BIT_GP_COUNTER_B  17
`define DSCG_BIT_GP_COUNTER_A  16
`define DSCG_BIT_TWO_WIRE_B    14
`define DSCG_BIT_TWO_WIRE_A    12
`define DSCG_BIT_SYNC_SERIAL_B 5
`define DSCG_BIT_SYNC_SERIAL_A 4
`define DSCG_BIT_ASYNC_SERIAL_B 1
`define DSCG_BIT_ASYNC_SERIAL_A 0

// writable bits and reset values
`define DSCG_GATE_WMASK      32'h030f_5033
`define DSCG_GATE_RESET      32'h0000_0000
`define DSCG_RUN_CFG_WMASK   32'h0000_0001
`define DSCG_RUN_CFG_RESET   32'h0000_0000
`define DSCG_BIT_AUTO_GATING 0

// interrupt status and mask layout
`define DSCG_IRQ_WMASK       32'h0000_0003
`define DSCG_IRQ_RESET       32'h0000_0000
`define DSCG_BIT_IRQ_FAULT   0
`define DSCG_BIT_IRQ_SWITCH  1

`endif

/* File: dscg_pkg.sv */
// types shared by the deep-sleep clock gate controller
package dscg_pkg;

  typedef enum logic [1:0] {
    dscg_mode_run,
    dscg_mode_sleep,
    dscg_mode_deep
  } dscg_mode_e;

  // access from the peripheral bus toward one gated unit
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [4:0] unit;
  } dscg_unit_req_s;

  // answer one cycle after the request
  typedef struct packed {
    logic done;
    logic fault;
  } dscg_unit_resp_s;

  // named clock enables of the controlled units
  typedef struct packed {
    logic comparator_b_gate;
    logic comparator_a_gate;
    logic gp_counter_d_gate;
    logic gp_counter_c_gate;
    logic gp_counter_b_gate;
    logic gp_counter_a_gate;
    logic two_wire_b_gate;
    logic two_wire_a_gate;
    logic sync_serial_b_gate;
    logic sync_serial_a_gate;
    logic async_serial_b_gate;
    logic async_serial_a_gate;
  } dscg_unit_en_s;

endpackage : dscg_pkg

/* File: dscg_access_check.sv */
// checks peripheral accesses against the active clock gate vector
`timescale 1ns/1ns
module dscg_access_check #(
  parameter int GATE_W = 32
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // active gate vector
  input  wire logic [GATE_W-1:0]        gate,
  // peripheral access
  input  wire dscg_pkg::dscg_unit_req_s req,
  output dscg_pkg::dscg_unit_resp_s     resp
);
  import dscg_pkg::*;

  dscg_unit_resp_s resp_reg;

  // a unit index on a reserved position reads a zero gate bit and faults too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_reg <= '0;
    end else begin
      resp_reg.done  <= req.valid;
      resp_reg.fault <= req.valid & ~gate[req.unit];
    end
  end

  assign resp = resp_reg;

endmodule : dscg_access_check

/* File: dscg_top_sva.sv */
// port-level assertions of the deep-sleep clock gate controller
`timescale 1ns/1ns
`include "dscg_defs.svh"
module dscg_top_sva
  import dscg_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int GATE_W = 32
) (
  // clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // apb strobes
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  // unit side
  input wire dscg_pkg::dscg_mode_e      power_mode,
  input wire dscg_pkg::dscg_unit_req_s  unit_req,
  input wire dscg_pkg::dscg_unit_resp_s unit_resp,
  input wire logic [GATE_W-1:0]         unit_clk_en,
  input wire dscg_pkg::dscg_unit_en_s   unit_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  resp_next_a: assert property (unit_req.valid |=> unit_resp.done)
    else $error("unit access not answered");
  resp_idle_a: assert property (!unit_req.valid |=> !unit_resp.done)
    else $error("answer without unit access");
  fault_off_a: assert property (unit_req.valid && !unit_clk_en[unit_req.unit] |=> unit_resp.fault)
    else $error("gated unit access not faulted");
  fault_on_a: assert property (unit_req.valid && unit_clk_en[unit_req.unit] |=> !unit_resp.fault)
    else $error("clocked unit access faulted");
  reserved_zero_a: assert property ((32'(unit_clk_en) & ~`DSCG_GATE_WMASK) == 32'h0)
    else $error("reserved enable bit set");
  unit_map_a: assert property (unit_en == {unit_clk_en[25:24], unit_clk_en[19:16],
      unit_clk_en[14], unit_clk_en[12], unit_clk_en[5:4], unit_clk_en[1:0]})
    else $error("named enables differ from vector");
  reset_zero_a: assert property ($rose(presetn) |-> unit_clk_en == '0)
    else $error("enables not zero after reset");
  // enables may only move after a register write or a power mode change;
  // the write lands at its access edge and the enable register follows one edge later
  gate_change_a: assert property ($changed(unit_clk_en) |-> $past(psel && penable && pwrite, 2)
      || $past(power_mode, 2) != $past(power_mode))
    else $error("enable vector changed without cause");
endmodule : dscg_top_sva

/* File: tb_deep_sleep_clock_gate_ctrl.sv */
// self-checking bench of the deep-sleep clock gate controller
`timescale 1ns/1ns
`include "dscg_defs.svh"
module tb_deep_sleep_clock_gate_ctrl;
  import dscg_pkg::*;
  logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]     paddr = '0;
  logic [31:0]     pwdata = '0, prdata, q, d, unit_clk_en;
  logic [31:0]     gm [3] = '{default: '0};
  logic [11:0]     goff [3] = '{`DSCG_OFF_RUN_GATE, `DSCG_OFF_SLEEP_GATE, `DSCG_OFF_DEEP_GATE};
  // the unused code 3 must behave as run
  dscg_mode_e      modes [4] = '{dscg_mode_run, dscg_mode_sleep, dscg_mode_deep,
                                 dscg_mode_e'(2'd3)};
  logic [3:0]      pstrb = 4'hf;
  logic            pready, pslverr, irq, err, auto_m = 0;
  dscg_mode_e      power_mode = dscg_mode_run;
  dscg_unit_req_s  unit_req = '0;
  dscg_unit_resp_s unit_resp;
  dscg_unit_en_s   unit_en;
  int              bad_count = 0, tests_run = 0;

  dscg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .power_mode(power_mode), .unit_req(unit_req),
    .unit_resp(unit_resp), .unit_clk_en(unit_clk_en), .unit_en(unit_en), .irq(irq));

  always #25 pclk = ~pclk;

  function automatic logic [31:0] exp_en(input dscg_mode_e m);
    if (!auto_m || (m != dscg_mode_sleep && m != dscg_mode_deep)) return gm[0];
    return (m == dscg_mode_deep) ? gm[2] : gm[1];
  endfunction : exp_en

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // one apb transfer, then an idle cycle so no strobe is driven twice at one edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic acc(input logic [4:0] u);
    logic [31:0] g;
    g = exp_en(power_mode);
    unit_req <= '{valid: 1'b1, write: 1'($urandom), unit: u};
    @(posedge pclk);
    unit_req.valid <= 1'b0;
    @(negedge pclk);
    chk(unit_clk_en, g);
    chk(32'(unit_resp), {30'h0, 1'b1, ~g[u]});
    @(posedge pclk);
  endtask : acc

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    #2000000;
    bad_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hb15c549c));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (goff[j]) begin
      apb(1'b0, goff[j], '0);
      chk(q, 32'h0);
    end
    acc(5'd0);
    $display("test reset done");
    // first pass writes all ones to hit every reserved bit
    for (int i = 0; i < 4; i++) begin
      foreach (goff[j]) begin
        d = (i == 0) ? 32'hffff_ffff : $urandom;
        apb(1'b1, goff[j], d);
        apb(1'b0, goff[j], '0);
        chk(q, d & `DSCG_GATE_WMASK);
        gm[j] = d & `DSCG_GATE_WMASK;
      end
      auto_m = i[0];
      apb(1'b1, `DSCG_OFF_RUN_CFG, {31'h0, auto_m});
      foreach (modes[k]) begin
        power_mode <= modes[k];
        repeat (2) @(posedge pclk);
        for (int u = 0; u < 32; u++) acc(u[4:0]);
      end
    end
    $display("test gating done");
    // read-modify-write that keeps the reserved bits, then a half-word write
    apb(1'b0, `DSCG_OFF_DEEP_GATE, '0);
    d = q ^ 32'h0100_0011;
    apb(1'b1, `DSCG_OFF_DEEP_GATE, d);
    apb(1'b0, `DSCG_OFF_DEEP_GATE, '0);
    chk(q, d & `DSCG_GATE_WMASK);
    pstrb <= 4'h3;
    apb(1'b1, `DSCG_OFF_DEEP_GATE, ~d);
    pstrb <= 4'hf;
    apb(1'b0, `DSCG_OFF_DEEP_GATE, '0);
    chk(q, {d[31:16], ~d[15:0]} & `DSCG_GATE_WMASK);
    $display("test lanes done");
    apb(1'b0, `DSCG_OFF_IRQ_STATUS, '0);
    chk(q, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `DSCG_OFF_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `DSCG_OFF_IRQ_STATUS, 32'h3);
    chk({31'h0, irq}, 32'h0);
    // a fault landing at the clearing access edge must survive the clear
    fork
      apb(1'b1, `DSCG_OFF_IRQ_STATUS, 32'h1);
      begin
        unit_req <= '{valid: 1'b1, write: 1'b0, unit: 5'd2};
        @(posedge pclk);
        unit_req.valid <= 1'b0;
      end
    join
    apb(1'b0, `DSCG_OFF_IRQ_STATUS, '0);
    chk(q, 32'h1);
    chk({31'h0, irq}, 32'h1);
    $display("test interrupt done");
    apb(1'b0, 12'h300, '0);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    $display("test unmapped done");
    print_verdict();
  end
endmodule : tb_deep_sleep_clock_gate_ctrl

bind dscg_top dscg_top_sva #(.ADDR_W(ADDR_W), .GATE_W(GATE_W)) i_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .power_mode(power_mode), .unit_req(unit_req), .unit_resp(unit_resp),
  .unit_clk_en(unit_clk_en), .unit_en(unit_en));
